// [core/ueim_pkg.sv]
// package: register map, field layout and carrier types of the endpoint irq mask block
//
// Summary of operation
// - irq when any enabled status bit set
// - disabled status still sets, no irq
// - tx enable at 0x006, resets 0x000f
// - rx enable at 0x008, resets 0x000e
// - tx enable bits 3..1 gate tx endpoints
// - tx bit 0 gates shared endpoint zero
// - rx bits 3..1 gate; bit 0 zero
// - bits 15:4 read zero; software preserves them
// - reading status clears its active bits
// - unconfigured endpoint status reads zero
package ueim_pkg;

  // printed offsets include 0x006, so these are indices; byte address = 4 * index
  localparam logic [7:0]  TX_STATUS_IDX   = 8'h02;
  localparam logic [7:0]  RX_STATUS_IDX   = 8'h04;
  localparam logic [7:0]  TX_ENABLE_IDX   = 8'h06;
  localparam logic [7:0]  RX_ENABLE_IDX   = 8'h08;
  localparam logic [7:0]  EP_CONFIG_IDX   = 8'h10;

  localparam int          EP_COUNT        = 4;
  localparam int          REG_WIDTH       = 16;
  localparam int          ENDPOINT_ZERO_BIT = 0;

  localparam logic [15:0] TX_ENABLE_RESET = 16'h000f;
  localparam logic [15:0] RX_ENABLE_RESET = 16'h000e;
  localparam logic [3:0]  TX_ENABLE_MASK  = 4'hf;
  localparam logic [3:0]  RX_ENABLE_MASK  = 4'he;
  localparam logic [3:0]  EP_CONFIG_RESET = 4'hf;

  typedef struct packed {
    logic [3:0] tx;
    logic [3:0] rx;
  } ueim_ep_type;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  index;
    logic        valid;
  } ueim_addr_type;

endpackage : ueim_pkg

// [core/ueim_status_bank.sv]
// module: one read-to-clear endpoint status register
`timescale 1ns/1ps
module ueim_status_bank #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // events and control
  input  wire logic [WIDTH-1:0] event_set,
  input  wire logic [WIDTH-1:0] configured,
  input  wire logic             read_clear,
  // state
  output logic      [WIDTH-1:0] status
);

  logic [WIDTH-1:0] status_r;
  logic [WIDTH-1:0] status_nxt;

  // event in the clearing cycle survives the clear
  always_comb begin
    status_nxt = read_clear ? '0 : status_r;
    status_nxt = (status_nxt | event_set) & configured;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign status = status_r;

  a_clear_on_read: assert property (@(posedge hclk) disable iff (!hresetn)
    read_clear && event_set == '0 |=> status_r == '0)
    else $error("status not cleared by read");

  a_unconfig_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (status_r & ~$past(configured)) == '0)
    else $error("unconfigured status bit set");

endmodule : ueim_status_bank

// [core/ueim_top.sv]
// module: endpoint interrupt enable masking with AHB-Lite register slave
`timescale 1ns/1ps
module ueim_top (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // endpoint events, one-cycle pulses
  input  wire logic [3:0]  tx_event,
  input  wire logic [3:0]  rx_event,
  // interrupt request
  output logic             usb_irq
);

  ////////////////////////////////////////////////////////////////////////
  // address phase capture

  ueim_pkg::ueim_addr_type aph_r;
  ueim_pkg::ueim_addr_type aph_nxt;
  logic [31:0]             hrdata_r;
  logic [31:0]             hrdata_nxt;

  always_comb begin
    aph_nxt.sel   = hsel && hready && htrans[1];
    aph_nxt.write = hwrite;
    aph_nxt.index = haddr[9:2];
    aph_nxt.valid = (haddr[1:0] == 2'h0) && (hsize == 3'h2);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_r <= '0;
    end else begin
      aph_r <= aph_nxt;
    end
  end

  logic wr_en;
  logic rd_tx_status;
  logic rd_rx_status;
  assign wr_en = aph_r.sel && aph_r.write && aph_r.valid;
  assign rd_tx_status = aph_nxt.sel && !hwrite && aph_nxt.valid
                        && haddr[9:2] == ueim_pkg::TX_STATUS_IDX;
  assign rd_rx_status = aph_nxt.sel && !hwrite && aph_nxt.valid
                        && haddr[9:2] == ueim_pkg::RX_STATUS_IDX;

  ////////////////////////////////////////////////////////////////////////
  // enable and configuration registers

  logic [3:0] tx_en_r;
  logic [3:0] tx_en_nxt;
  logic [3:0] rx_en_r;
  logic [3:0] rx_en_nxt;
  logic [3:0] cfg_r;
  logic [3:0] cfg_nxt;

  always_comb begin
    tx_en_nxt = tx_en_r;
    rx_en_nxt = rx_en_r;
    cfg_nxt   = cfg_r;
    if (wr_en) begin
      case (aph_r.index)
        ueim_pkg::TX_ENABLE_IDX: begin
          tx_en_nxt = hwdata[3:0] & ueim_pkg::TX_ENABLE_MASK;
        end
        ueim_pkg::RX_ENABLE_IDX: begin
          rx_en_nxt = hwdata[3:0] & ueim_pkg::RX_ENABLE_MASK;
        end
        ueim_pkg::EP_CONFIG_IDX: begin
          cfg_nxt = hwdata[3:0];
        end
        default: begin
          cfg_nxt = cfg_r;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_en_r <= ueim_pkg::TX_ENABLE_RESET[3:0];
      rx_en_r <= ueim_pkg::RX_ENABLE_RESET[3:0];
      cfg_r   <= ueim_pkg::EP_CONFIG_RESET;
    end else begin
      tx_en_r <= tx_en_nxt;
      rx_en_r <= rx_en_nxt;
      cfg_r   <= cfg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status banks; rx bit 0 never exists, endpoint zero is on tx side

  ueim_pkg::ueim_ep_type status;

  ueim_status_bank #(.WIDTH(4)) u_tx_status (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .event_set  (tx_event),
    .configured (cfg_r),
    .read_clear (rd_tx_status),
    .status     (status.tx)
  );

  ueim_status_bank #(.WIDTH(4)) u_rx_status (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .event_set  (rx_event),
    .configured (cfg_r & ueim_pkg::RX_ENABLE_MASK),
    .read_clear (rd_rx_status),
    .status     (status.rx)
  );

  ////////////////////////////////////////////////////////////////////////
  // read data and interrupt

  logic       irq_r;
  logic       irq_nxt;
  logic       hreadyout_r;
  logic       hresp_r;
  logic [3:0] rd_field;
  logic [3:0] tx_set_hit;
  logic [3:0] rx_set_hit;
  logic [3:0] tx_st_nxt;
  logic [3:0] rx_st_nxt;
  logic [3:0] tx_hit_nxt;
  logic [3:0] rx_hit_nxt;

  always_comb begin
    rd_field = 4'h0;
    case (haddr[9:2])
      ueim_pkg::TX_STATUS_IDX: rd_field = status.tx;
      ueim_pkg::RX_STATUS_IDX: rd_field = status.rx;
      ueim_pkg::TX_ENABLE_IDX: rd_field = tx_en_r;
      ueim_pkg::RX_ENABLE_IDX: rd_field = rx_en_r;
      ueim_pkg::EP_CONFIG_IDX: rd_field = cfg_r;
      default:                 rd_field = 4'h0;
    endcase
    hrdata_nxt = hrdata_r;
    if (aph_nxt.sel && !hwrite) begin
      hrdata_nxt = {28'h0000000, aph_nxt.valid ? rd_field : 4'h0};
    end
  end

  // next status mirrors the banks so irq is not delayed beyond status
  always_comb begin
    tx_set_hit = tx_event & cfg_r;
    rx_set_hit = rx_event & cfg_r & ueim_pkg::RX_ENABLE_MASK;
    tx_st_nxt  = ((rd_tx_status ? 4'h0 : status.tx) & cfg_r) | tx_set_hit;
    rx_st_nxt  = ((rd_rx_status ? 4'h0 : status.rx) & cfg_r & ueim_pkg::RX_ENABLE_MASK)
                 | rx_set_hit;
  end

  for (genvar g = 0; g < ueim_pkg::EP_COUNT; g++) begin : g_mask
    assign tx_hit_nxt[g] = tx_en_nxt[g] & tx_st_nxt[g];
    assign rx_hit_nxt[g] = rx_en_nxt[g] & rx_st_nxt[g];
  end

  assign irq_nxt = (|tx_hit_nxt) || (|rx_hit_nxt);

  // zero wait states, response always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r    <= 32'h00000000;
      irq_r       <= 1'b0;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      hrdata_r    <= hrdata_nxt;
      irq_r       <= irq_nxt;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;
  assign usb_irq   = irq_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_irq_tracks_masked: assert property (@(posedge hclk) disable iff (!hresetn)
    usb_irq == |((status.tx & tx_en_r) | (status.rx & rx_en_r)))
    else $error("irq differs from masked status");

  a_masked_no_irq: assert property (@(posedge hclk) disable iff (!hresetn)
    (status.tx & tx_en_r) == 4'h0 && (status.rx & rx_en_r) == 4'h0 |-> !usb_irq)
    else $error("irq from disabled bit");

  a_ep0_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    status.tx[0] && tx_en_r[0] |-> usb_irq)
    else $error("endpoint zero irq missing");

  a_ep0_masked: assert property (@(posedge hclk) disable iff (!hresetn)
    !tx_en_r[0] && (status.tx[3:1] & tx_en_r[3:1]) == 3'h0
    && (status.rx & rx_en_r) == 4'h0 |-> !usb_irq)
    else $error("masked endpoint zero raised irq");

  a_tx_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    |(status.tx[3:1] & tx_en_r[3:1]) |-> usb_irq)
    else $error("tx endpoint irq missing");

  a_rx_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    |(status.rx[3:1] & rx_en_r[3:1]) |-> usb_irq)
    else $error("rx endpoint irq missing");

  a_rx_bit0_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_en_r[0] == 1'b0 && status.rx[0] == 1'b0)
    else $error("rx bit 0 not zero");

  a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:4] == 28'h0000000)
    else $error("reserved read bits not zero");

  a_unconfig_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (status.tx & ~$past(cfg_r)) == 4'h0 && (status.rx & ~$past(cfg_r)) == 4'h0)
    else $error("unconfigured endpoint status set");

  a_tx_en_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_en && aph_r.index == ueim_pkg::TX_ENABLE_IDX |=> tx_en_r == $past(hwdata[3:0]))
    else $error("tx enable write lost");

  a_rx_en_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_en && aph_r.index == ueim_pkg::RX_ENABLE_IDX
    |=> rx_en_r == ($past(hwdata[3:0]) & ueim_pkg::RX_ENABLE_MASK))
    else $error("rx enable write wrong");

  a_cfg_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_en && aph_r.index == ueim_pkg::EP_CONFIG_IDX |=> cfg_r == $past(hwdata[3:0]))
    else $error("endpoint config write lost");

  a_unmapped_write: assert property (@(posedge hclk) disable iff (!hresetn)
    wr_en && aph_r.index != ueim_pkg::TX_ENABLE_IDX && aph_r.index != ueim_pkg::RX_ENABLE_IDX
    && aph_r.index != ueim_pkg::EP_CONFIG_IDX |=> $stable(tx_en_r) && $stable(cfg_r))
    else $error("write to unmapped index changed state");

  a_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !(aph_nxt.sel && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without a read");

  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus response not okay");

  ////////////////////////////////////////////////////////////////////////
  // read-clear and event steps

  sequence s_tx_status_read;
    rd_tx_status && tx_event == 4'h0;
  endsequence

  sequence s_rx_status_read;
    rd_rx_status && rx_event == 4'h0;
  endsequence

  sequence s_tx_event_seen;
    tx_set_hit != 4'h0;
  endsequence

  sequence s_rx_event_seen;
    rx_set_hit != 4'h0;
  endsequence

  sequence s_irq_rise;
    $rose(usb_irq);
  endsequence

  a_tx_read_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    s_tx_status_read |=> status.tx == 4'h0)
    else $error("tx status not cleared by read");

  a_rx_read_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    s_rx_status_read |=> status.rx == 4'h0)
    else $error("rx status not cleared by read");

  a_tx_read_data: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_tx_status |=> hrdata[3:0] == $past(status.tx))
    else $error("tx status read data wrong");

  a_rx_read_data: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_rx_status |=> hrdata[3:0] == $past(status.rx))
    else $error("rx status read data wrong");

  a_tx_event_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    s_tx_event_seen |=> (status.tx & $past(tx_set_hit)) == $past(tx_set_hit))
    else $error("tx event did not set status");

  a_rx_event_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    s_rx_event_seen |=> (status.rx & $past(rx_set_hit)) == $past(rx_set_hit))
    else $error("rx event did not set status");

  a_irq_rise_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    s_irq_rise |-> |(status.tx & tx_en_r) || |(status.rx & rx_en_r))
    else $error("irq rose without an enabled status bit");

endmodule : ueim_top

// [bench/ueim_irq_sink.sv]
// partner model: interrupt controller input that counts usb request assertions
`timescale 1ns/1ps
module ueim_irq_sink (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // request from the block
  input  wire logic       usb_irq,
  // observed rising edges
  output logic      [7:0] irq_count_r
);
  logic irq_q_r;

  // level-sensitive request; one count per assertion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q_r     <= 1'b0;
      irq_count_r <= 8'h00;
    end else begin
      irq_q_r <= usb_irq;
      if (usb_irq && !irq_q_r) begin
        irq_count_r <= irq_count_r + 8'h01;
      end
    end
  end
endmodule : ueim_irq_sink

// [bench/testbench.sv]
// testbench: register access, masking and read-clear of endpoint interrupts
`timescale 1ns/1ps
module testbench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  tx_event = 4'h0;
  logic [3:0]  rx_event = 4'h0;
  logic        usb_irq;
  logic [7:0]  irq_count_r;
  logic [31:0] rd;
  logic [3:0]  m;
  int          num_errors = 0;
  int          n_checks = 0;

  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  ueim_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tx_event(tx_event), .rx_event(rx_event),
    .usb_irq(usb_irq));
  ueim_irq_sink sink (.hclk(hclk), .hresetn(hresetn), .usb_irq(usb_irq),
    .irq_count_r(irq_count_r));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ad(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction : ad

  task automatic test_done();
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // single word transfer; waits for hready in both phases
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask : bus

  task automatic pulse(input logic [3:0] t, input logic [3:0] r);
    @(posedge hclk);
    tx_event <= t;
    rx_event <= r;
    @(posedge hclk);
    tx_event <= 4'h0;
    rx_event <= 4'h0;
    #1;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge hclk);
    num_errors++;
    test_done();
  end

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, ad(ueim_pkg::TX_ENABLE_IDX), 32'h0);
    chk("tx_en_rst", rd, 32'h000f);
    chk("hresp", {31'h0, hresp}, 32'h0);
    chk("hreadyout", {31'h0, hreadyout}, 32'h1);
    bus(1'b0, ad(ueim_pkg::RX_ENABLE_IDX), 32'h0);
    chk("rx_en_rst", rd, 32'h000e);
    bus(1'b1, ad(ueim_pkg::TX_ENABLE_IDX), 32'hffff);
    bus(1'b1, ad(ueim_pkg::RX_ENABLE_IDX), 32'hffff);
    bus(1'b0, ad(ueim_pkg::TX_ENABLE_IDX), 32'h0);
    chk("tx_en_rsv", rd, 32'h000f);
    bus(1'b0, ad(ueim_pkg::RX_ENABLE_IDX), 32'h0);
    chk("rx_en_rsv", rd, 32'h000e);
    bus(1'b0, 32'h0000_00fc, 32'h0);
    chk("unmapped", rd, 32'h0);
    // per-endpoint masking, enable after the event, then read-clear
    for (int s = 0; s < 2; s++) begin
      for (int i = s; i < 4; i++) begin
        m = 4'(1 << i);
        bus(1'b1, ad(ueim_pkg::TX_ENABLE_IDX), 32'h0);
        bus(1'b1, ad(ueim_pkg::RX_ENABLE_IDX), 32'h0);
        if (s == 0) pulse(m, 4'h0);
        else pulse(4'h0, m);
        repeat (2) @(posedge hclk);
        #1 chk("irq_masked", {31'h0, usb_irq}, 32'h0);
        bus(1'b1, ad(s == 0 ? ueim_pkg::TX_ENABLE_IDX : ueim_pkg::RX_ENABLE_IDX), {28'h0, m});
        repeat (2) @(posedge hclk);
        #1 chk("irq_enabled", {31'h0, usb_irq}, 32'h1);
        bus(1'b0, ad(s == 0 ? ueim_pkg::TX_STATUS_IDX : ueim_pkg::RX_STATUS_IDX), 32'h0);
        chk("status", rd, {28'h0, m});
        chk("irq_cleared", {31'h0, usb_irq}, 32'h0);
        bus(1'b0, ad(s == 0 ? ueim_pkg::TX_STATUS_IDX : ueim_pkg::RX_STATUS_IDX), 32'h0);
        chk("status_clr", rd, 32'h0);
      end
    end
    chk("irq_count", {24'h0, irq_count_r}, 32'h7);
    // write to an unmapped word leaves the tx enable alone
    bus(1'b1, 32'h0000_00fc, 32'hffff_ffff);
    bus(1'b0, ad(ueim_pkg::TX_ENABLE_IDX), 32'h0);
    chk("tx_en_hold", rd, 32'h0);
    // only endpoint zero configured
    bus(1'b1, ad(ueim_pkg::EP_CONFIG_IDX), 32'h1);
    pulse(4'hf, 4'hf);
    bus(1'b0, ad(ueim_pkg::TX_STATUS_IDX), 32'h0);
    chk("tx_cfg", rd, 32'h1);
    bus(1'b0, ad(ueim_pkg::RX_STATUS_IDX), 32'h0);
    chk("rx_cfg", rd, 32'h0);
    test_done();
  end
endmodule : testbench
